// *** verilog/irq_enable_regs.svh ***
`ifndef IRQ_ENABLE_REGS_SVH
`define IRQ_ENABLE_REGS_SVH

// register map, one aligned 32-bit word per register
`define OFS_ENABLE_BASE   8'h00
`define OFS_FLAG_BASE     8'h14
`define OFS_STATUS        8'h28
`define OFS_CLEAR         8'h2c
`define OFS_IRQ_EN        8'h30
`define OFS_STRIDE        8'h04

`define ENABLE_REG_COUNT  5
`define ENABLE_RESET      16'h0000
`define STATUS_RESET      6'h00

// implemented bit masks of the five enable registers
`define EN0_IMPL_MASK     16'h7fff
`define EN1_IMPL_MASK     16'hfffb
`define EN2_IMPL_MASK     16'hdfff
`define EN3_IMPL_MASK     16'h39ff
`define EN4_IMPL_MASK     16'h00f6

// selected field positions
`define EN0_COMPARE_CH1   2
`define EN0_CAPTURE_CH1   1
`define EN0_EXT_PIN0      0
`define EN1_UART_B_TX     15
`define EN1_UART_B_RX     14
`define EN1_CHANGE_NOTIFY 3
`define EN1_I2C_A_MASTER  1
`define EN1_I2C_A_SLAVE   0
`define EN2_TIMER_SIX     15
`define EN2_SPI_B_ERROR   0
`define EN3_AUDIO_EVENT   12
`define EN3_AUDIO_ERROR   11
`define EN3_CAN_B_EVENT   8
`define EN4_CAN_B_TX      7
`define EN4_CAN_A_TX      6
`define EN4_DMA_CH7_DONE  5
`define EN4_DMA_CH6_DONE  4
`define EN4_UART_B_ERROR  2
`define EN4_UART_A_ERROR  1

// status bit of the bus error event
`define STAT_UNMAPPED     5

`endif

// *** verilog/irq_enable_pkg.sv ***
`default_nettype none
package irq_enable_pkg;

  typedef logic [15:0] word_type;
  typedef word_type [4:0] bank_type;

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  strb;
  } apb_req_type;

  typedef struct packed {
    logic       unmapped;
    logic [4:0] bank_rise;
  } event_type;

  typedef enum logic [2:0] {
    KIND_NONE   = 3'h0,
    KIND_ENABLE = 3'h1,
    KIND_FLAG   = 3'h2,
    KIND_STATUS = 3'h3,
    KIND_CLEAR  = 3'h4,
    KIND_IRQ_EN = 3'h5
  } reg_kind_type;

  typedef struct packed {
    reg_kind_type kind;
    logic [2:0]   idx;
  } decode_type;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_SETUP  = 2'b01,
    BUS_ACCESS = 2'b11
  } bus_phase_type;

endpackage : irq_enable_pkg
`default_nettype wire

// *** verilog/irq_gate.sv ***
`default_nettype none
module irq_gate #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] flag_i,
  input  wire logic [WIDTH-1:0] enable_i,
  output logic      [WIDTH-1:0] req_o,
  output logic                  rise_o
);

  logic [WIDTH-1:0] req_reg;
  logic [WIDTH-1:0] req_next;
  logic             rise_reg;
  logic             rise_next;

  // recomputed on every edge, so a dropped flag or enable clears the request at the next edge
  always_comb begin
    req_next  = flag_i & enable_i;                  // [RULE_01] [RULE_12] [RULE_13]
    rise_next = (|req_next) & ~(|req_reg);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_reg  <= '0;
      rise_reg <= 1'b0;
    end else begin
      req_reg  <= req_next;
      rise_reg <= rise_next;
    end
  end

  assign req_o  = req_reg;
  assign rise_o = rise_reg;

endmodule // irq_gate
`default_nettype wire

// *** verilog/interrupt_enable_bank.sv ***
`include "irq_enable_regs.svh"
`default_nettype none
// Overview of operation
// [RULE_01] An enable bit at 1 lets its source's request through and at 0 blocks it.
// [RULE_02] Unimplemented enable bits read as 0 and ignore writes.
// [RULE_03] Implemented enable bits are read/write and clear to 0 at reset.
// [RULE_04] Register 0 holds compare 1 at bit 2, capture 1 at bit 1, external pin 0 at bit 0.
// [RULE_05] Register 1 upper byte holds uart b tx/rx, pin 2, timers 5/4, compare 4/3, dma 2.
// [RULE_06] Register 1 lower byte holds capture 8/7, adc 2, pin 1, change notify, gap, i2c a.
// [RULE_07] Register 2 upper byte holds timer 6, dma 4, a gap at 13, compare 8..5, capture 6.
// [RULE_08] Register 2 lower byte holds capture 5..3, dma 3, can a event/rx, spi b event/error.
// [RULE_09] Register 3 upper byte has gaps at 15,14,10,9 and dma 5, audio event/error, can b.
// [RULE_10] Register 3 lower byte holds can b rx, pins 4/3, timers 9/8, i2c b, timer 7.
// [RULE_11] Register 4 holds can b/a tx, dma 7/6 and uart b/a error, all else unimplemented.
// [RULE_12] A flag reads 1 while its source has raised a request, whatever its enable; reads mask it by implemented bits only.
// [RULE_13] Each passed request is the AND of flag and enable, recomputed every cycle.
module interrupt_enable_bank #(
  parameter int ADDR_W = 8
) (
  input  wire logic                     MCLK_I,
  input  wire logic                     RESET_I,
  input  wire logic                     PSEL_I,
  input  wire logic                     PENABLE_I,
  input  wire logic                     PWRITE_I,
  input  wire logic [ADDR_W-1:0]        PADDR_I,
  input  wire logic [31:0]              PWDATA_I,
  input  wire logic [3:0]               PSTRB_I,
  output logic      [31:0]              PRDATA_O,
  output logic                          PREADY_O,
  output logic                          PSLVERR_O,
  input  wire irq_enable_pkg::bank_type FLAG_I,
  output var  irq_enable_pkg::bank_type REQ_O,
  output logic                          IRQ_O
);

  import irq_enable_pkg::*;

  localparam int NREG = `ENABLE_REG_COUNT;

  // implemented-bit mask of one enable register
  function automatic word_type impl_mask(input logic [2:0] idx);
    case (idx)
      3'h0:    impl_mask = `EN0_IMPL_MASK;               // [RULE_04]
      3'h1:    impl_mask = `EN1_IMPL_MASK;               // [RULE_05] [RULE_06]
      3'h2:    impl_mask = `EN2_IMPL_MASK;               // [RULE_07] [RULE_08]
      3'h3:    impl_mask = `EN3_IMPL_MASK;               // [RULE_09] [RULE_10]
      3'h4:    impl_mask = `EN4_IMPL_MASK;               // [RULE_11]
      default: impl_mask = 16'h0000;
    endcase
  endfunction

  // address decode, shared by the read and the write path
  function automatic decode_type decode(input logic [ADDR_W-1:0] addr);
    decode_type d;
    d.kind = KIND_NONE;
    d.idx  = 3'h0;
    for (int i = 0; i < NREG; i++) begin
      if (addr == ADDR_W'(`OFS_ENABLE_BASE + i * `OFS_STRIDE)) begin
        d.kind = KIND_ENABLE;
        d.idx  = 3'(i);
      end
      if (addr == ADDR_W'(`OFS_FLAG_BASE + i * `OFS_STRIDE)) begin
        d.kind = KIND_FLAG;
        d.idx  = 3'(i);
      end
    end
    if (addr == ADDR_W'(`OFS_STATUS)) begin
      d.kind = KIND_STATUS;
    end
    if (addr == ADDR_W'(`OFS_CLEAR)) begin
      d.kind = KIND_CLEAR;
    end
    if (addr == ADDR_W'(`OFS_IRQ_EN)) begin
      d.kind = KIND_IRQ_EN;
    end
    return d;
  endfunction

  // byte-lane merge; only the low two lanes carry register bits
  function automatic word_type merge(input word_type   old,
                                     input logic [15:0] wdata,
                                     input logic [1:0]  strb,
                                     input word_type    mask);
    word_type v;
    v = old;
    for (int b = 0; b < 2; b++) begin
      if (strb[b]) begin
        v[8*b +: 8] = wdata[8*b +: 8];
      end
    end
    return v & mask;                                     // [RULE_02]
  endfunction

  apb_req_type   req;
  decode_type    dec;
  logic          access_now;
  logic          setup_now;
  logic          wr_now;
  logic          legal_access;

  bus_phase_type phase_reg;
  bus_phase_type phase_next;

  // enable group: software view of the bank and the interrupt enable
  bank_type      enable_reg;
  bank_type      enable_next;
  logic [5:0]    irq_en_reg;
  logic [5:0]    irq_en_next;

  // status group: sticky events and the level interrupt
  event_type     status_reg;
  event_type     status_next;
  logic          irq_reg;
  logic          irq_next;

  // read group: held from the setup cycle through the access phase
  logic [31:0]   prdata_reg;
  logic [31:0]   prdata_next;
  logic          pslverr_reg;
  logic          pslverr_next;

  bank_type      req_bank;
  logic [4:0]    bank_rise;
  logic [5:0]    clear_bits;
  event_type     events;
  bank_type      enable_view;
  bank_type      flag_view;

  always_comb begin
    req.sel    = PSEL_I;
    req.enable = PENABLE_I;
    req.write  = PWRITE_I;
    req.addr   = 8'(PADDR_I);
    req.wdata  = PWDATA_I;
    req.strb   = PSTRB_I;
  end

  assign dec        = decode(PADDR_I);
  assign setup_now  = req.sel & ~req.enable;
  assign access_now = req.sel & req.enable;
  // a write needs its own setup cycle first, so a lone penable glitch cannot touch the bank
  assign legal_access = access_now & (phase_reg == BUS_SETUP);
  assign wr_now       = legal_access & req.write;

  // zero wait states: every access phase completes in its first cycle
  assign PREADY_O = access_now;

  // bus phase tracker
  always_comb begin
    phase_next = BUS_IDLE;
    unique case (phase_reg)
      BUS_IDLE, BUS_ACCESS: begin
        if (setup_now) begin
          phase_next = BUS_SETUP;
        end
      end
      BUS_SETUP: begin
        if (access_now) begin
          phase_next = BUS_ACCESS;
        end else if (setup_now) begin
          phase_next = BUS_SETUP;
        end
      end
      default: phase_next = BUS_IDLE;
    endcase
  end

  // masked views, so no read path can ever show an unimplemented bit
  generate
    for (genvar m = 0; m < NREG; m++) begin : g_view
      assign enable_view[m] = enable_reg[m] & impl_mask(3'(m));  // [RULE_02]
      assign flag_view[m]   = FLAG_I[m] & impl_mask(3'(m));      // [RULE_12]
    end
  endgenerate

  // read data and error are captured in the setup cycle so they are stable in the access phase
  always_comb begin
    prdata_next  = prdata_reg;
    pslverr_next = pslverr_reg;
    if (setup_now) begin
      prdata_next  = 32'h0000_0000;
      pslverr_next = 1'b0;
      unique case (dec.kind)
        KIND_ENABLE: prdata_next = {16'h0000, enable_view[dec.idx]}; // [RULE_02]
        KIND_FLAG:   prdata_next = {16'h0000, flag_view[dec.idx]};   // [RULE_12]
        KIND_STATUS: prdata_next = {26'h0000000, status_reg};
        KIND_CLEAR:  prdata_next = 32'h0000_0000;
        KIND_IRQ_EN: prdata_next = {26'h0000000, irq_en_reg};
        KIND_NONE:   pslverr_next = 1'b1;
      endcase
    end
  end

  // enable bank and interrupt enable; flag and status views are read-only
  always_comb begin
    enable_next = enable_reg;
    irq_en_next = irq_en_reg;
    clear_bits  = 6'h00;
    if (wr_now) begin
      unique case (dec.kind)
        KIND_ENABLE: begin
          enable_next[dec.idx] = merge(enable_reg[dec.idx], req.wdata[15:0],
                                       req.strb[1:0], impl_mask(dec.idx)); // [RULE_03]
        end
        KIND_CLEAR: begin
          if (req.strb[0]) begin
            clear_bits = req.wdata[5:0];
          end
        end
        KIND_IRQ_EN: begin
          if (req.strb[0]) begin
            irq_en_next = req.wdata[5:0];
          end
        end
        KIND_FLAG, KIND_STATUS, KIND_NONE: begin
        end
      endcase
    end
  end

  // per-register request gating
  generate
    for (genvar r = 0; r < NREG; r++) begin : g_bank
      irq_gate #(
        .WIDTH (16)
      ) u_gate (
        .clk_i    (MCLK_I),
        .rst_i    (RESET_I),
        .flag_i   (FLAG_I[r]),
        .enable_i (enable_reg[r]),
        .req_o    (req_bank[r]),
        .rise_o   (bank_rise[r])
      );
    end
  endgenerate

  // sticky status; a new event in the clearing cycle survives the clear
  always_comb begin
    events.bank_rise = bank_rise;
    events.unmapped  = access_now & (dec.kind == KIND_NONE);
    status_next      = event_type'((status_reg & ~clear_bits) | events);
    irq_next         = |(status_next & irq_en_next);
  end

  // one register process per group; the status group also takes clear_bits and irq_en_next from the enable group
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      phase_reg <= BUS_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // every source starts blocked after reset
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      enable_reg <= {NREG{`ENABLE_RESET}};               // [RULE_03]
      irq_en_reg <= 6'h00;
    end else begin
      enable_reg <= enable_next;
      irq_en_reg <= irq_en_next;
    end
  end

  // status and interrupt move together, so the level never lags its cause
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      status_reg <= `STATUS_RESET;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg    <= irq_next;
    end
  end

  assign PRDATA_O  = prdata_reg;
  assign PSLVERR_O = pslverr_reg & access_now;
  assign REQ_O     = req_bank;
  assign IRQ_O     = irq_reg;

endmodule // interrupt_enable_bank
`default_nettype wire

// *** verilog/irq_gate_fix_note.sv ***
`default_nettype none
`default_nettype wire

// *** testbench/irq_enable_checker.sv ***
`include "irq_enable_regs.svh"
`default_nettype none
module irq_enable_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic                     MCLK_I,
  input wire logic                     RESET_I,
  input wire logic                     PSEL_I,
  input wire logic                     PENABLE_I,
  input wire logic                     PWRITE_I,
  input wire logic [ADDR_W-1:0]        PADDR_I,
  input wire logic [31:0]              PRDATA_O,
  input wire logic                     PREADY_O,
  input wire logic                     PSLVERR_O,
  input wire irq_enable_pkg::bank_type FLAG_I,
  input wire irq_enable_pkg::bank_type REQ_O,
  input wire logic                     IRQ_O
);
  import irq_enable_pkg::*;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  localparam bank_type MASK = {`EN4_IMPL_MASK, `EN3_IMPL_MASK, `EN2_IMPL_MASK,
                               `EN1_IMPL_MASK, `EN0_IMPL_MASK};
  sequence s_access;
    PSEL_I && PENABLE_I;
  endsequence
  sequence s_rd_enable;
    s_access ##0 (!PWRITE_I && PADDR_I < 8'h14 && PADDR_I[1:0] == 2'b00);
  endsequence
  a_ready_zero_wait: assert property (
    PREADY_O == (PSEL_I && PENABLE_I)) else $error("ready not zero wait");
  a_read_masked: assert property (
    s_rd_enable |-> (PRDATA_O[15:0] & ~MASK[PADDR_I[4:2]]) == 16'h0000)
    else $error("unimplemented enable bit read as one");
  a_rdata_upper: assert property (
    s_access ##0 !PWRITE_I |-> PRDATA_O[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_slverr_in_access: assert property (
    PSLVERR_O |-> s_access) else $error("error outside access phase");
  a_req_flag_gate: assert property (
    (REQ_O & ~$past(FLAG_I)) == '0) else $error("request without flag");
  a_req_unimpl_zero: assert property (
    (REQ_O & ~MASK) == '0) else $error("request on unimplemented bit");
  a_reset_clear: assert property (
    $fell(RESET_I) |-> REQ_O == '0 && !IRQ_O && PRDATA_O == 32'h0)
    else $error("state not cleared by reset");
  a_irq_cause: assert property (
    $rose(IRQ_O) |-> $past(|REQ_O || PSEL_I) || $past(PSEL_I, 2))
    else $error("interrupt rose without cause");
endmodule // irq_enable_checker
`default_nettype wire

// *** testbench/tb_top.sv ***
`include "irq_enable_regs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_enable_pkg::*;
  localparam bank_type mask = {`EN4_IMPL_MASK, `EN3_IMPL_MASK, `EN2_IMPL_MASK,
                               `EN1_IMPL_MASK, `EN0_IMPL_MASK};
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdata, v, seed = 32'd47;
  logic [3:0]  pstrb = 4'hf;
  logic        ready, slverr, irq;
  bank_type    flag = '0, req, en = '0;
  logic [32:0] q[$];
  int          err_count = 0, n_compared = 0;
  always #5 clk = ~clk;
  interrupt_enable_bank #(.ADDR_W(8)) i_interrupt_enable_bank (
    .MCLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(rdata),
    .PREADY_O(ready), .PSLVERR_O(slverr), .FLAG_I(flag), .REQ_O(req), .IRQ_O(irq));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (ready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    q.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic rd_bank();
    for (int r = 0; r < 5; r++) rd(8'(4 * r), {17'h0, en[r]});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  always @(posedge clk) begin
    if (psel && pen && ready === 1'b1 && !pwr) begin
      chk(80'({slverr, rdata}), 80'(q.pop_front()));
    end
  end
  task automatic print_verdict();
    if (q.size() != 0) err_count++;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_bank();
    rd(8'h80, {1'b1, 32'h0});
    rd(8'h06, {1'b1, 32'h0});
    rd(`OFS_STATUS, 33'h20);
    for (int r = 0; r < 5; r++) begin
      v = xs() | 32'h0000ffff * (r == 4);
      en[r] = v[15:0] & mask[r];
      bus(1'b1, 8'(4 * r), v);
    end
    rd_bank();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      flag <= bank_type'(80'({xs(), xs(), xs()}));
      settle(2);
      chk(req, flag & en);
      rd(8'(`OFS_FLAG_BASE + 4 * k), {17'h0, flag[k] & mask[k]});
    end
    @(posedge clk);
    flag <= '0;
    en[0] = mask[0];
    bus(1'b1, 8'h00, 32'hffff);
    bus(1'b1, `OFS_CLEAR, 32'h3f);
    rd(`OFS_STATUS, 33'h0);
    bus(1'b1, `OFS_IRQ_EN, 32'h01);
    flag[0][`EN0_COMPARE_CH1] <= 1'b1;
    settle(4);
    chk(80'(irq), 80'(1));
    rd(`OFS_STATUS, 33'h1);
    bus(1'b1, `OFS_IRQ_EN, 32'h0);
    settle(1);
    chk(80'(irq), 80'(0));
    en[0] = '0;
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, `OFS_CLEAR, 32'h3f);
    bus(1'b1, `OFS_IRQ_EN, 32'h01);
    settle(3);
    chk(req, '0);
    chk(80'(irq), 80'(0));
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    en = '0;
    rd_bank();
    @(posedge clk);
    print_verdict();
  end
endmodule // tb_top
bind interrupt_enable_bank irq_enable_checker #(.ADDR_W(ADDR_W)) i_irq_enable_checker (
  .MCLK_I(MCLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .FLAG_I(FLAG_I), .REQ_O(REQ_O), .IRQ_O(IRQ_O));
`default_nettype wire
